// file: sloat_chk.sv
module sloat_chk #(
  parameter int ADC_WAKE_CYCLES = sloat_pkg::ADC_WAKE_CYC,
  parameter int OUT_WAKE_CYCLES = sloat_pkg::OUT_WAKE_CYC
) (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic [7:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input sloat_pkg::sloat_sample_t sample_in,
  input wire logic                sync_request_in,
  input sloat_pkg::sloat_lane_t   lane_out,
  input wire logic                adc_ready,
  input wire logic                out_ready
);
  localparam int MF_WIN = 40;
  logic        requant_q;
  logic        pdwn_q;
  logic [15:0] mf_q;
  logic [15:0] k_cnt;
  logic [7:0]  low_cnt;
  logic [7:0]  age;
  logic [2:0]  a_cnt;
  logic [31:0] wk_cnt;
  wire ctrl_wr = reg_wr && reg_addr == sloat_pkg::REG_CTRL;
  wire k_now = lane_out.valid && lane_out.is_ctrl && lane_out.octet == sloat_pkg::K28_5;
  wire a_now = lane_out.valid && lane_out.is_ctrl && lane_out.octet == sloat_pkg::ILAS_A;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    if (srst) begin
      {requant_q, pdwn_q, age} <= '0;
      mf_q <= sloat_pkg::MF_LEN_RESET;
    end else begin
      if (ctrl_wr) {requant_q, pdwn_q} <= reg_wdata[1:0];
      // A requantizer change leaves a stale pipeline behind it, so latency waits it out.
      age <= (ctrl_wr && reg_wdata[1] != requant_q) ? 8'h00 : age + 8'(age != 8'hff);
      if (reg_wr && reg_addr == sloat_pkg::REG_MF_LEN)
        mf_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
    end
  end
  always_ff @(posedge clk) begin
    k_cnt <= (srst || !k_now) ? 16'h0000 : k_cnt + 16'h0001;
    low_cnt <= (srst || sync_request_in) ? 8'h00 : low_cnt + 8'(low_cnt != 8'hff);
    // Payload octets of the alignment phase are not samples; data starts after four ends.
    if (srst || k_now) begin
      a_cnt <= 3'h0;
    end else if (a_now && a_cnt != 3'h4) begin
      a_cnt <= a_cnt + 3'h1;
    end
    // Mirrors the wake counters so the exact wake edge is checked without a long range.
    wk_cnt <= (srst || pdwn_q) ? 32'h0 : wk_cnt + 32'(wk_cnt != 32'hffffffff);
  end
  sequence s_k;
    lane_out.valid && lane_out.is_ctrl && lane_out.octet == sloat_pkg::K28_5;
  endsequence
  sequence s_ilas;
    lane_out.valid && lane_out.is_ctrl && lane_out.octet == sloat_pkg::ILAS_R;
  endsequence
  property p_cgs_len; s_k ##1 s_ilas |-> k_cnt >= mf_q; endproperty
  a_cgs_len: assert property (p_cgs_len) else $error("short code group phase");
  property p_sync_k; low_cnt >= 8'd6 && out_ready && $past(out_ready, 4) |-> s_k; endproperty
  a_sync_k: assert property (p_sync_k) else $error("no K while sync low");
  property p_rel_ilas; $rose(sync_request_in) ##0 s_k |-> ##[1:MF_WIN] s_ilas; endproperty
  a_rel_ilas: assert property (p_rel_ilas) else $error("no alignment after release");
  property p_lat;
    lane_out.valid && !lane_out.is_ctrl && a_cnt == 3'h4 && !requant_q && age > 8'h28
      |-> lane_out.octet == $past(sample_in.data[7:0], 37);
  endproperty
  a_lat: assert property (p_lat) else $error("base latency wrong");
  property p_lat_nsr;
    lane_out.valid && !lane_out.is_ctrl && a_cnt == 3'h4 && requant_q && age > 8'h28
      |-> lane_out.octet == $past(sample_in.data[7:0], 39);
  endproperty
  a_lat_nsr: assert property (p_lat_nsr) else $error("requantizer latency wrong");
  property p_pd_drop; ctrl_wr && reg_wdata[0] |-> ##[1:2] !adc_ready && !out_ready; endproperty
  a_pd_drop: assert property (p_pd_drop) else $error("ready kept in power-down");
  property p_adc_early; wk_cnt <= 32'(ADC_WAKE_CYCLES) |-> !adc_ready; endproperty
  a_adc_early: assert property (p_adc_early) else $error("converter ready too early");
  property p_adc_wake; wk_cnt == 32'(ADC_WAKE_CYCLES) + 32'h1 |-> adc_ready; endproperty
  a_adc_wake: assert property (p_adc_wake) else $error("converter wake time wrong");
  property p_out_early; wk_cnt <= 32'(OUT_WAKE_CYCLES) |-> !out_ready; endproperty
  a_out_early: assert property (p_out_early) else $error("output ready too early");
  property p_out_wake; wk_cnt == 32'(OUT_WAKE_CYCLES) + 32'h1 |-> out_ready; endproperty
  a_out_wake: assert property (p_out_wake) else $error("output wake time wrong");
endmodule // sloat_chk

bind sloat_link sloat_chk #(
  .ADC_WAKE_CYCLES(ADC_WAKE_CYCLES), .OUT_WAKE_CYCLES(OUT_WAKE_CYCLES)
) chk_u (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .sample_in(sample_in), .sync_request_in(sync_request_in), .lane_out(lane_out),
  .adc_ready(adc_ready), .out_ready(out_ready)
);

// file: sloat_delay.sv
module sloat_delay (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  requant_en,
  input  sloat_pkg::sloat_sample_t   din,
  output sloat_pkg::sloat_sample_t   dout
);

  sloat_pkg::sloat_sample_t pipe_reg [sloat_pkg::PIPE_DEPTH];

  // A fixed shift line keeps latency exact regardless of traffic.
  genvar i;
  generate
    for (i = 0; i < sloat_pkg::PIPE_DEPTH; i++) begin : g_stage
      if (i == 0) begin : g_first
        always_ff @(posedge clk) begin
          if (srst) begin
            pipe_reg[i] <= '0;
          end else begin
            pipe_reg[i] <= din;
          end
        end
      end else begin : g_rest
        always_ff @(posedge clk) begin
          if (srst) begin
            pipe_reg[i] <= '0;
          end else begin
            pipe_reg[i] <= pipe_reg[i-1];
          end
        end
      end
    end
  endgenerate

  // Tap chosen so the extra requantizer stages add exactly two cycles.
  assign dout = requant_en ? pipe_reg[sloat_pkg::PIPE_DEPTH-1]
                       : pipe_reg[sloat_pkg::BASE_LATENCY-1];

endmodule // sloat_delay

// file: sloat_link.sv
// Behaviour
// - Sample rate after divider must be 40 to 250 MSPS.
// - Lane carries twenty UI per sample; lane rate at most 5 Gbps.
// - During code-group sync, K.28 sent for at least one multiframe.
// - Samples reach lane output exactly 36 sample cycles after sampling; the lane output register makes it 37 cycles here.
// - Requantizer enabled adds exactly two cycles of latency.
// - Converter needs about 250 ms after power-down before normal use.
// - Serial output needs about 50 ms after power-down before normal use.
//
// Implementation choices: the address map and the address-and-strobe port.
module sloat_link #(
  parameter int ADC_WAKE_CYCLES = sloat_pkg::ADC_WAKE_CYC,
  parameter int OUT_WAKE_CYCLES = sloat_pkg::OUT_WAKE_CYC
) (
  input  wire logic                           clk,
  input  wire logic                           srst,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [31:0]                         reg_rdata,
  input  wire logic [7:0]                     rate_msps,
  input  sloat_pkg::sloat_sample_t            sample_in,
  input  wire logic                           sync_request_in,
  input  wire logic                           sysref_in,
  output sloat_pkg::sloat_lane_t              lane_out,
  output logic                                adc_ready,
  output logic                                out_ready
);

  typedef enum logic [2:0] {
    SLOAT_IDLE,
    SLOAT_CGS,
    SLOAT_ILAS,
    SLOAT_DATA
  } sloat_state_t;

  logic                      pdwn_reg;
  logic                      requant_reg;
  logic                      sub1_reg;
  logic [15:0]               mf_len_reg;
  logic                      sync_m_reg;
  logic                      sync_s_reg;
  logic                      sref_m_reg;
  logic                      sref_s_reg;
  logic                      sref_d_reg;
  sloat_state_t              state_reg;
  logic [15:0]               oct_cnt_reg;
  logic [15:0]               cgs_cnt_reg;
  logic [1:0]                ilas_mf_reg;
  logic                      cgs_done_reg;
  logic                      rate_ok;
  sloat_pkg::sloat_sample_t  delayed;
  logic                      mf_end;

  always_ff @(posedge clk) begin
    if (srst) begin
      pdwn_reg   <= 1'b0;
      requant_reg <= 1'b0;
      sub1_reg   <= 1'b0;
      mf_len_reg <= sloat_pkg::MF_LEN_RESET;
    end else if (reg_wr) begin
      if (reg_addr == sloat_pkg::REG_CTRL) begin
        pdwn_reg <= reg_wdata[sloat_pkg::CTRL_PDWN_BIT];
        requant_reg <= reg_wdata[sloat_pkg::CTRL_REQUANT_BIT];
        sub1_reg <= reg_wdata[sloat_pkg::CTRL_SUB1_BIT];
      end
      if (reg_addr == sloat_pkg::REG_MF_LEN) begin
        mf_len_reg <= (reg_wdata[15:0] == 16'h0) ? 16'h1 : reg_wdata[15:0];
      end
    end
  end

  // Rate check against the documented window and the lane ceiling.
  assign rate_ok = (rate_msps >= 8'(sloat_pkg::RATE_MIN_MSPS)) &&
                   (rate_msps <= 8'(sloat_pkg::RATE_MAX_MSPS)) &&
                   (32'(rate_msps) * sloat_pkg::LANE_UI_PER_SAMPLE
                    <= sloat_pkg::LANE_MAX_MBPS);

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        sloat_pkg::REG_CTRL:   reg_rdata <= {29'h0, sub1_reg, requant_reg, pdwn_reg};
        sloat_pkg::REG_MF_LEN: reg_rdata <= {16'h0, mf_len_reg};
        sloat_pkg::REG_STATUS: reg_rdata <= {26'h0, rate_ok, out_ready, adc_ready,
                                             state_reg};
        sloat_pkg::REG_RATE:   reg_rdata <= {24'h0, rate_msps};
        default:               reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Pins from the far receiver are synchronised before use.
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_m_reg <= 1'b1;
      sync_s_reg <= 1'b1;
      sref_m_reg <= 1'b0;
      sref_s_reg <= 1'b0;
      sref_d_reg <= 1'b0;
    end else begin
      sync_m_reg <= sync_request_in;
      sync_s_reg <= sync_m_reg;
      sref_m_reg <= sysref_in;
      sref_s_reg <= sref_m_reg;
      sref_d_reg <= sref_s_reg;
    end
  end

  sloat_wake u_adc_wake (
    .clk         (clk),
    .srst        (srst),
    .pdwn        (pdwn_reg),
    .wake_cycles (32'(ADC_WAKE_CYCLES)),
    .ready       (adc_ready)
  );

  sloat_wake u_out_wake (
    .clk         (clk),
    .srst        (srst),
    .pdwn        (pdwn_reg),
    .wake_cycles (32'(OUT_WAKE_CYCLES)),
    .ready       (out_ready)
  );

  sloat_delay u_delay (
    .clk    (clk),
    .srst   (srst),
    .requant_en (requant_reg),
    .din    (sample_in),
    .dout   (delayed)
  );

  // Multiframe counter; a system reference rise realigns it in subclass 1.
  assign mf_end = (oct_cnt_reg == mf_len_reg - 16'h1);

  always_ff @(posedge clk) begin
    if (srst) begin
      oct_cnt_reg <= '0;
    end else if (sub1_reg && sref_s_reg && !sref_d_reg) begin
      oct_cnt_reg <= '0;
    end else if (mf_end) begin
      oct_cnt_reg <= '0;
    end else begin
      oct_cnt_reg <= oct_cnt_reg + 16'h1;
    end
  end

  // Sync stays low as long as the receiver wants it; release only counts after a
  // full multiframe of K characters so a short pulse cannot skip the phase.
  always_ff @(posedge clk) begin
    if (srst || !out_ready) begin
      state_reg    <= SLOAT_IDLE;
      cgs_cnt_reg  <= '0;
      cgs_done_reg <= 1'b0;
      ilas_mf_reg  <= '0;
    end else begin
      unique case (state_reg)
        SLOAT_IDLE: begin
          if (!sync_s_reg) begin
            state_reg <= SLOAT_CGS;
          end
        end
        SLOAT_CGS: begin
          if (cgs_cnt_reg >= mf_len_reg - 16'h1) begin
            cgs_done_reg <= 1'b1;
          end else begin
            cgs_cnt_reg <= cgs_cnt_reg + 16'h1;
          end
          if (sync_s_reg && cgs_done_reg && mf_end) begin
            state_reg   <= SLOAT_ILAS;
            ilas_mf_reg <= '0;
          end
        end
        SLOAT_ILAS: begin
          if (!sync_s_reg) begin
            state_reg    <= SLOAT_CGS;
            cgs_cnt_reg  <= '0;
            cgs_done_reg <= 1'b0;
          end else if (mf_end) begin
            ilas_mf_reg <= ilas_mf_reg + 2'h1;
            if (ilas_mf_reg == 2'h3) begin
              state_reg <= SLOAT_DATA;
            end
          end
        end
        SLOAT_DATA: begin
          if (!sync_s_reg) begin
            state_reg    <= SLOAT_CGS;
            cgs_cnt_reg  <= '0;
            cgs_done_reg <= 1'b0;
          end
        end
        default: state_reg <= SLOAT_IDLE;
      endcase
    end
  end

  // Samples are shown in the low octet; serialisation happens past this block.
  always_ff @(posedge clk) begin
    if (srst) begin
      lane_out <= '0;
    end else begin
      unique case (state_reg)
        SLOAT_CGS: lane_out <= '{valid: 1'b1, is_ctrl: 1'b1, octet: sloat_pkg::K28_5};
        SLOAT_ILAS: begin
          if (oct_cnt_reg == 16'h0) begin
            lane_out <= '{valid: 1'b1, is_ctrl: 1'b1, octet: sloat_pkg::ILAS_R};
          end else if (mf_end) begin
            lane_out <= '{valid: 1'b1, is_ctrl: 1'b1, octet: sloat_pkg::ILAS_A};
          end else begin
            lane_out <= '{valid: 1'b1, is_ctrl: 1'b0, octet: oct_cnt_reg[7:0]};
          end
        end
        SLOAT_DATA: lane_out <= '{valid: delayed.valid, is_ctrl: 1'b0,
                                  octet: delayed.data[7:0]};
        default: lane_out <= '0;
      endcase
    end
  end

endmodule // sloat_link

// file: sloat_pkg.sv
package sloat_pkg;

  localparam int SAMPLE_W = 11;
  localparam int LANE_UI_PER_SAMPLE = 20;
  localparam int RATE_MIN_MSPS = 40;
  localparam int RATE_MAX_MSPS = 250;
  localparam int LANE_MAX_MBPS = 5000;
  localparam int CLK_MHZ = 100;
  localparam int BASE_LATENCY = 36;
  localparam int REQUANT_EXTRA_LATENCY = 2;
  localparam int PIPE_DEPTH = BASE_LATENCY + REQUANT_EXTRA_LATENCY;
  localparam int ADC_WAKE_MS = 250;
  localparam int OUT_WAKE_MS = 50;
  localparam int ADC_WAKE_CYC = ADC_WAKE_MS * 1000 * CLK_MHZ;
  localparam int OUT_WAKE_CYC = OUT_WAKE_MS * 1000 * CLK_MHZ;
  localparam int MF_CNT_W = 16;
  localparam int WAKE_CNT_W = 32;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] ILAS_R = 8'h1c;
  localparam logic [7:0] ILAS_A = 8'h7c;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MF_LEN = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RATE = 8'h0c;
  localparam int CTRL_PDWN_BIT = 0;
  localparam int CTRL_REQUANT_BIT = 1;
  localparam int CTRL_SUB1_BIT = 2;
  localparam logic [15:0] MF_LEN_RESET = 16'h0020;

  typedef enum logic [1:0] {
    SLOAT_SUB0,
    SLOAT_SUB1
  } sloat_subclass_t;

  typedef struct packed {
    logic                valid;
    logic                is_ctrl;
    logic [7:0]          octet;
  } sloat_lane_t;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } sloat_sample_t;

endpackage

// file: sloat_rx.sv
module sloat_rx (
  input wire logic        clk,
  input wire logic        go,
  input wire logic        sub1,
  input wire logic [15:0] mf_len,
  input wire logic [7:0]  slack,
  output logic            sync_request_in,
  output logic            sysref_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sync_request_in = 1'b1;
    sysref_in = 1'b0;
  end
  always @(posedge clk) begin
    if (go) begin
      sync_request_in <= 1'b0;
      sysref_in <= sub1;
      @(posedge clk);
      sysref_in <= 1'b0;
      // A slow receiver simply adds slack on top of the minimum wait.
      repeat ((sub1 ? 6 : 5) * mf_len + slack) @(posedge clk);
      sync_request_in <= 1'b1;
    end
  end
endmodule // sloat_rx

// file: sloat_wake.sv
module sloat_wake (
  input  wire logic                              clk,
  input  wire logic                              srst,
  input  wire logic                              pdwn,
  input  wire logic [sloat_pkg::WAKE_CNT_W-1:0]  wake_cycles,
  output logic                                   ready
);

  logic [sloat_pkg::WAKE_CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (srst || pdwn) begin
      cnt_reg <= '0;
      ready   <= 1'b0;
    end else if (cnt_reg < wake_cycles) begin
      cnt_reg <= cnt_reg + 32'h1;
    end else begin
      ready <= 1'b1;
    end
  end

endmodule // sloat_wake

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0;
  logic                     srst = 1'b1;
  logic [7:0]               reg_addr = 8'h00;
  logic [31:0]              reg_wdata = 32'h0;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic                     rd_d = 1'b0;
  logic [31:0]              reg_rdata;
  logic [7:0]               rate_msps = 8'hc8;
  sloat_pkg::sloat_sample_t sample_in = '0;
  sloat_pkg::sloat_lane_t   lane_out;
  logic                     sync_request_in, sysref_in, adc_ready, out_ready;
  logic                     go = 1'b0;
  logic                     sub1 = 1'b0;
  logic [7:0]               slack = 8'h00;
  logic [31:0]              exp_q[$];
  logic [31:0]              msk_q[$];
  logic [7:0]               rates[5] = '{8'h27, 8'h28, 8'h7d, 8'hfa, 8'hfb};
  int                       failures = 0;
  int                       samples_checked = 0;
  always #5 clk = ~clk;
  sloat_link #(.ADC_WAKE_CYCLES(20), .OUT_WAKE_CYCLES(10)) dut_u (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rate_msps(rate_msps), .sample_in(sample_in),
    .sync_request_in(sync_request_in), .sysref_in(sysref_in), .lane_out(lane_out),
    .adc_ready(adc_ready), .out_ready(out_ready));
  sloat_rx rx_u (.clk(clk), .go(go), .sub1(sub1), .mf_len(16'h0008), .slack(slack),
    .sync_request_in(sync_request_in), .sysref_in(sysref_in));
  task automatic cmp(string name, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", name, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_lane(logic c);
    int n;
    n = 0;
    while ({lane_out.valid, lane_out.is_ctrl} !== {1'b1, c} && n < 500) begin
      @(posedge clk);
      n++;
    end
    cmp("lane_wait", 32'd1, 32'(n < 500));
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Register answers are judged one cycle after the read strobe, the only cycle they stand.
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) cmp("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
  end
  always @(posedge clk) sample_in <= {1'b1, 11'($urandom)};
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial begin
    void'($urandom(37));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (30) @(posedge clk);
    rd(sloat_pkg::REG_STATUS, 32'h38, 32'h38);
    rd(8'h10, 32'h0, 32'hffffffff);
    rd(sloat_pkg::REG_MF_LEN, 32'h20, 32'hffff);
    wr(sloat_pkg::REG_MF_LEN, 32'h8);
    rd(sloat_pkg::REG_MF_LEN, 32'h8, 32'hffff);
    foreach (rates[i]) begin
      rate_msps <= rates[i];
      repeat (3) @(posedge clk);
      rd(sloat_pkg::REG_STATUS, 32'(rates[i] >= 40 && 20 * rates[i] <= 5000) << 5, 32'h20);
    end
    rate_msps <= 8'hc8;
    rd(sloat_pkg::REG_RATE, 32'hc8, 32'hffffffff);
    for (int s = 0; s < 2; s++) begin
      wr(sloat_pkg::REG_CTRL, 32'(s) << sloat_pkg::CTRL_SUB1_BIT);
      sub1 <= s[0];
      slack <= 8'($urandom_range(9));
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      wait_lane(1'b1);
      wait_lane(1'b0);
      repeat (60) @(posedge clk);
    end
    wr(sloat_pkg::REG_CTRL, 32'h2);
    rd(sloat_pkg::REG_CTRL, 32'h2, 32'hffffffff);
    repeat (80) @(posedge clk);
    wr(sloat_pkg::REG_CTRL, 32'h1);
    rd(sloat_pkg::REG_STATUS, 32'h0, 32'h18);
    wr(sloat_pkg::REG_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    rd(sloat_pkg::REG_STATUS, 32'h18, 32'h18);
    wr(sloat_pkg::REG_MF_LEN, 32'h0);
    rd(sloat_pkg::REG_MF_LEN, 32'h1, 32'hffff);
    // The last answer is judged on the edge at which the task returns, so let that edge finish first.
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule // testbench
